/* File: prs_rom_self_read.v */
/*
 program rom self-read block: address, data and control registers on the
 core's special register port, a two-cycle fetch sequencer on the rom port,
 and the gate that stops an external programmer reading a protected rom.
 assumes the core issues at most one register access per enable, that the
 rom answers in the cycle after its strobe, and that clk_en marks each
 instruction cycle.
 a programmer read already in flight when protection rises still completes;
 the rom port is shared, so programmer reads wait for idle gaps.
*/
// Functional notes
// - fetch runs over the next two cycles
// - word valid after second idle instruction
// - data registers hold until next read or software write
// - protected rom refuses external programmer reads
// - internal reads ignore code protection setting
// - control bit seven always reads one
// - unimplemented bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.vh"

module prs_rom_self_read (
   // clock and reset
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   // special register port from the core
   input wire [8:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // program rom port
   output reg rom_req,
   output reg [12:0] rom_addr,
   input wire [13:0] rom_rdata,
   // external programmer read path
   input wire code_protect,
   input wire prog_rd,
   input wire [12:0] prog_addr,
   output reg prog_rd_ok,
   output reg [13:0] prog_rdata,
   // status
   output reg busy
);

   localparam ST_IDLE = 3'b001;
   localparam ST_FETCH = 3'b010;
   localparam ST_LATCH = 3'b100;

   reg [7:0] addr_low_reg;
   reg [4:0] addr_high_reg;
   reg [7:0] data_low_reg;
   reg [5:0] data_high_reg;
   reg rd_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg cp_s1_reg;
   reg cp_s2_reg;
   reg prog_pend_reg;
   reg [7:0] rdata_next;
   reg fetch_wait_reg;
   reg fetch_take_reg;
   reg prog_take_reg;
   wire reg_wr;
   wire self_start;
   wire prog_start;

   function hit;
      input [8:0] a;
      input [8:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // software writes land only on an instruction cycle while no fetch runs
   assign reg_wr = sfr_wr && clk_en && (state_reg == ST_IDLE);
   assign self_start = clk_en && (state_reg == ST_IDLE) && rd_reg;
   // programmer reads use idle gaps between instruction cycles, one word in flight
   assign prog_start = !clk_en && (state_reg == ST_IDLE) && !rd_reg && prog_rd &&
      !cp_s2_reg &&
      !prog_pend_reg && !prog_take_reg;

   // fetch sequencer: one instruction cycle to strobe and capture, one to clear the request
   always @* begin
      case (state_reg)
         ST_IDLE: state_next = rd_reg ? ST_FETCH : ST_IDLE;
         ST_FETCH: state_next = ST_LATCH;
         ST_LATCH: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always @* begin
      rdata_next = 8'h00;
      if (hit(sfr_addr, `PRS_OFF_DATA_LOW))
         rdata_next = data_low_reg;
      else if (hit(sfr_addr, `PRS_OFF_ADDR_LOW))
         rdata_next = addr_low_reg;
      else if (hit(sfr_addr, `PRS_OFF_DATA_HIGH))
         rdata_next = {2'b00, data_high_reg};
      else if (hit(sfr_addr, `PRS_OFF_ADDR_HIGH))
         rdata_next = {3'b000, addr_high_reg};
      else if (hit(sfr_addr, `PRS_OFF_CONTROL))
         rdata_next = {1'b1, 6'h00, rd_reg};
   end

   // code protect strap comes from the fuse domain, so synchronise it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cp_s1_reg <= 1'b1;
         cp_s2_reg <= 1'b1;
      end else begin
         cp_s1_reg <= code_protect;
         cp_s2_reg <= cp_s1_reg;
      end
   end

   // sequencer state and the busy flag move only on instruction cycles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         busy <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         busy <= (state_next != ST_IDLE);
      end
   end

   // address writes are refused mid-fetch so the word stays coherent
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_low_reg <= 8'h00;
         addr_high_reg <= 5'h00;
      end else if (reg_wr) begin
         if (hit(sfr_addr, `PRS_OFF_ADDR_LOW))
            addr_low_reg <= sfr_wdata;
         if (hit(sfr_addr, `PRS_OFF_ADDR_HIGH))
            addr_high_reg <= sfr_wdata[4:0];
      end
   end

   // the request bit drops on the last fetch cycle, when no write can land
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == ST_LATCH)
            rd_reg <= 1'b0;
         else if (reg_wr && hit(sfr_addr, `PRS_OFF_CONTROL) && sfr_wdata[`PRS_CTRL_RD_BIT])
            rd_reg <= 1'b1;
      end
   end

   // the rom answers one cycle after its strobe, so a word is taken two edges later
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_req <= 1'b0;
         rom_addr <= 13'h0000;
         fetch_wait_reg <= 1'b0;
         fetch_take_reg <= 1'b0;
         prog_pend_reg <= 1'b0;
         prog_take_reg <= 1'b0;
      end else begin
         rom_req <= self_start || prog_start;
         fetch_wait_reg <= self_start;
         fetch_take_reg <= fetch_wait_reg;
         prog_pend_reg <= prog_start;
         prog_take_reg <= prog_pend_reg;
         if (self_start) begin
            // self read never looks at the protect strap
            rom_addr <= {addr_high_reg, addr_low_reg};
         end else if (prog_start) begin
            rom_addr <= prog_addr;
         end
      end
   end

   // a fetch and a software write never meet, since writes wait for idle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_low_reg <= 8'h00;
         data_high_reg <= 6'h00;
      end else if (fetch_take_reg) begin
         data_low_reg <= rom_rdata[7:0];
         data_high_reg <= rom_rdata[13:8];
      end else if (reg_wr) begin
         if (hit(sfr_addr, `PRS_OFF_DATA_LOW))
            data_low_reg <= sfr_wdata;
         if (hit(sfr_addr, `PRS_OFF_DATA_HIGH))
            data_high_reg <= sfr_wdata[5:0];
      end
   end

   // refused reads show zero rather than the last word served
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_rd_ok <= 1'b0;
         prog_rdata <= 14'h0000;
      end else begin
         prog_rd_ok <= prog_take_reg;
         if (prog_take_reg)
            prog_rdata <= rom_rdata;
         else if (prog_rd && cp_s2_reg)
            prog_rdata <= 14'h0000;
      end
   end

   // read data is registered and holds between reads
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
         sfr_rdata <= rdata_next;
   end

endmodule
`default_nettype wire

/* File: prs_consts.vh */
/*
 holds register offsets, field positions, masks and timing counts for the
 program rom self-read block. assumes nothing; definitions only.
*/
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH

`define PRS_OFF_DATA_LOW 9'h10c
`define PRS_OFF_ADDR_LOW 9'h10d
`define PRS_OFF_DATA_HIGH 9'h10e
`define PRS_OFF_ADDR_HIGH 9'h10f
`define PRS_OFF_CONTROL 9'h18c

`define PRS_CTRL_RD_BIT 0
`define PRS_CTRL_ONE_BIT 7
`define PRS_ADDR_HIGH_MASK 8'h1f
`define PRS_DATA_HIGH_MASK 8'h3f
`define PRS_ROM_AW 13
`define PRS_ROM_DW 14

`define PRS_FETCH_CYCLES 2'h2

`endif

/* File: prs_rom_model.sv */
/* rom array model; assumes one clock and a strobe per word */
`timescale 1ns/1ps
`default_nettype none
module prs_rom_model(input wire clk, input wire rom_req, input wire [12:0] rom_addr,
   output logic [13:0] rom_rdata);
   // off-strobe cycles show the inverse so a late sample is caught
   always @(posedge clk)
      rom_rdata <= rom_req ? {rom_addr[0], ~rom_addr} : ~rom_rdata;
endmodule
`default_nettype wire

/* File: prs_monitor.sv */
/* port checker for the self-read block; bound at the foot */
`timescale 1ns/1ps
`default_nettype none
module prs_monitor(input wire clk, input wire rst_n, input wire clk_en, input wire sfr_rd,
   input wire [8:0] sfr_addr, input wire [7:0] sfr_rdata, input wire rom_req,
   input wire busy, input wire code_protect, input wire prog_rd_ok);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_fetch_go: assert property ($rose(busy) |-> rom_req && $past(clk_en))
      else $error("start");
   chk_one_strobe: assert property ($rose(busy) |=> !rom_req && busy)
      else $error("strobe");
   chk_rd_clear: assert property ($fell(busy) |-> $past(clk_en))
      else $error("clear");
   chk_prot_block: assert property (code_protect[*6] |-> !prog_rd_ok)
      else $error("protect");
   chk_idle_share: assert property (prog_rd_ok |-> !busy)
      else $error("share");
   chk_ctl_one: assert property ($past(sfr_rd) && $past(sfr_addr) == 9'h18c |-> sfr_rdata[7])
      else $error("msb");
   chk_ctl_zero: assert property ($past(sfr_rd) && $past(sfr_addr) == 9'h18c |->
      sfr_rdata[6:1] == 6'h0) else $error("ctl");
   chk_addrh_zero: assert property ($past(sfr_rd) && $past(sfr_addr) == 9'h10f |->
      sfr_rdata[7:5] == 3'h0) else $error("addrh");
   cover property ($rose(busy));
   cover property ($fell(busy));
   cover property (prog_rd_ok);
endmodule
bind prs_rom_self_read prs_monitor u_mon(.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
   .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .rom_req(rom_req),
   .busy(busy), .code_protect(code_protect), .prog_rd_ok(prog_rd_ok));
`default_nettype wire

/* File: testbench.sv */
/* self-checking bench; needs the rom model and checker */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 0, rst_n = 0, clk_en = 0, sfr_wr = 0, sfr_rd = 0, code_protect = 1, prog_rd = 0;
   logic [8:0] sfr_addr = 0;
   logic [7:0] sfr_wdata = 0, v;
   logic [12:0] prog_addr = 0, a;
   logic [13:0] w;
   wire [7:0] sfr_rdata;
   wire rom_req, prog_rd_ok, busy;
   wire [12:0] rom_addr;
   wire [13:0] rom_rdata, prog_rdata;
   int err_total = 0, comparisons = 0, cyc = 0, n;
   prs_rom_self_read DUT(.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .rom_req(rom_req), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
      .code_protect(code_protect), .prog_rd(prog_rd), .prog_addr(prog_addr),
      .prog_rd_ok(prog_rd_ok), .prog_rdata(prog_rdata), .busy(busy));
   prs_rom_model u_rom(.clk(clk), .rom_req(rom_req), .rom_addr(rom_addr),
      .rom_rdata(rom_rdata));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      clk_en <= cyc % 4 == 2;
      if (cyc == 3000) begin
         err_total++;
         report_and_stop;
      end
   end
   task chk(input string s, input logic [13:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // a write is held until an instruction-cycle edge takes it
   task wr(input logic [8:0] ad, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= ad;
      sfr_wdata <= d;
      sfr_wr <= 1;
      @(posedge clk iff clk_en);
      sfr_wr <= 0;
   endtask
   task rd(input logic [8:0] ad);
      @(posedge clk);
      sfr_addr <= ad;
      sfr_rd <= 1;
      @(posedge clk);
      sfr_rd <= 0;
      @(negedge clk);
      v = sfr_rdata;
   endtask
   task report_and_stop;
      if (err_total == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1;
      rd(9'h18c);
      chk("ctl", v, 8'h80);
      for (int i = 0; i < 2; i++) begin
         a = i ? 13'h1f5a : 13'h0033;
         w = {a[0], ~a};
         @(posedge clk);
         code_protect <= i[0];
         wr(9'h10f, {3'h7, a[12:8]});
         wr(9'h10d, a[7:0]);
         rd(9'h10f);
         chk("addrh", v, a[12:8]);
         wr(9'h18c, 8'hff);
         rd(9'h18c);
         chk("pending", v, 8'h81);
         repeat (2) @(posedge clk iff clk_en);
         @(negedge clk);
         chk("busy", busy, 1);
         @(posedge clk iff clk_en);
         rd(9'h18c);
         chk("done", v, 8'h80);
         chk("idle", busy, 0);
         rd(9'h10c);
         chk("dl", v, w[7:0]);
         rd(9'h10e);
         chk("dh", v, w[13:8]);
         wr(9'h10d, 8'h99);
         rd(9'h10c);
         chk("kept", v, w[7:0]);
      end
      @(posedge clk);
      prog_addr <= 13'h0abc;
      prog_rd <= 1;
      n = 0;
      repeat (40) @(negedge clk) n += prog_rd_ok;
      chk("refused", n, 0);
      chk("pdata0", prog_rdata, 0);
      @(posedge clk);
      code_protect <= 0;
      n = 0;
      while (!prog_rd_ok && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("served", n < 40, 1);
      chk("pdata", prog_rdata, {1'b0, ~13'h0abc});
      @(posedge clk);
      prog_rd <= 0;
      report_and_stop;
   end
endmodule
`default_nettype wire
